/* gfm_board_model.sv */
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// board side of the four pins
// -------------------------------------------------------------------
module gfm_board_model
    import gfm_pkg::*;
(
    input wire logic [gfm_pkg::GFM_PINS-1:0] gpio_out,  // device drive
    input wire logic [gfm_pkg::GFM_PINS-1:0] gpio_oe,   // device enable
    input wire logic [gfm_pkg::GFM_PINS-1:0] board_val, // board level
    input wire logic [gfm_pkg::GFM_PINS-1:0] board_en,  // board drives
    output logic [gfm_pkg::GFM_PINS-1:0] pin_level      // resolved wire
);
    always_comb begin
        for (int i = 0; i < GFM_PINS; i++) begin
            if (gpio_oe[i]) begin
                pin_level[i] = gpio_out[i];
            end else if (board_en[i]) begin
                pin_level[i] = board_val[i];
            end else begin
                // weak pull-down, so a released pin never floats
                pin_level[i] = 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* gfm_gpio_mux.sv */
`timescale 1ns/1ps
`default_nettype none

module gfm_gpio_mux
    import gfm_pkg::*;
#(
    parameter int PINS = gfm_pkg::GFM_PINS
) (
    input wire logic clock,                        // 200 MHz clock
    input wire logic rst_n,                        // sync reset, low
    input wire logic ce,                           // freezes all state
    input wire gfm_pkg::gfm_reg_req_t reg_req,     // register access
    output logic [gfm_pkg::GFM_DW-1:0] reg_rdata,  // read data
    output logic reg_rvalid,                       // read data valid
    input wire gfm_pkg::gfm_status_t status,       // internal flags
    input wire logic [gfm_pkg::GFM_PINS-1:0] gpio_in,  // pin levels
    output logic [gfm_pkg::GFM_PINS-1:0] gpio_out,     // pin drive
    output logic [gfm_pkg::GFM_PINS-1:0] gpio_oe,      // drive enable
    output logic [gfm_pkg::GFM_CLKS-1:0] clk_oe_ctrl,  // pin oe levels
    output logic [gfm_pkg::GFM_CLKS-1:0] clk_oe_ctrl_active, // pin owns
    output logic manual_reference_select,          // pin ref select
    output logic manual_reference_select_active    // pin owns select
);

    // -----------------------------------------------------------------
    // parameter check
    // -----------------------------------------------------------------
    // the per-pin function table is fixed, so only four pins are served
    initial begin
        if (PINS != GFM_PINS) $error("gfm_gpio_mux: PINS must be 4");
    end

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [GFM_PINS-1:0] pin_sync;

    gfm_pin_sync #(
        .W(GFM_PINS)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .d_in(gpio_in),
        .q_out(pin_sync)
    );

    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    logic [GFM_PINS-1:0] dir_q, dir_d;
    logic [GFM_PINS-1:0] isel2_q, isel2_d;
    logic [GFM_PINS-1:0] isel1_q, isel1_d;
    logic [GFM_PINS-1:0] isel0_q, isel0_d;
    logic [GFM_PINS-1:0] osel2_q, osel2_d;
    logic [GFM_PINS-1:0] osel1_q, osel1_d;
    logic [GFM_PINS-1:0] osel0_q, osel0_d;
    logic [GFM_PINS-1:0] out_val_q, out_val_d;
    logic [GFM_PINS-1:0] in_val_q, in_val_d;
    logic [GFM_DW-1:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [GFM_SELW-1:0] isel [GFM_PINS];
    logic [GFM_SELW-1:0] osel [GFM_PINS];
    logic [GFM_PINS-1:0] plain_in;

    // each selector is gathered from one bit of three registers
    for (genvar g = 0; g < GFM_PINS; g++) begin : g_sel
        assign isel[g] = {isel2_q[g], isel1_q[g], isel0_q[g]};
        assign osel[g] = {osel2_q[g], osel1_q[g], osel0_q[g]};
        assign plain_in[g] = !dir_q[g] && isel[g] == GFM_FN_PLAIN;
    end

    always_comb begin
        dir_d = dir_q;
        isel2_d = isel2_q;
        isel1_d = isel1_q;
        isel0_d = isel0_q;
        osel2_d = osel2_q;
        osel1_d = osel1_q;
        osel0_d = osel0_q;
        out_val_d = out_val_q;
        // non-plain pins read back zero rather than a stale level
        in_val_d = pin_sync & plain_in;
        rdata_d = rdata_q;
        rvalid_d = reg_req.rd;
        // upper reserved bits are dropped; they read back as zero
        if (reg_req.wr) begin
            if (reg_req.addr == GFM_ADDR_DIR) begin
                dir_d = reg_req.wdata[GFM_PINS-1:0];
            end else if (reg_req.addr == GFM_ADDR_ISEL2) begin
                isel2_d = reg_req.wdata[GFM_PINS-1:0];
            end else if (reg_req.addr == GFM_ADDR_ISEL1) begin
                isel1_d = reg_req.wdata[GFM_PINS-1:0];
            end else if (reg_req.addr == GFM_ADDR_ISEL0) begin
                isel0_d = reg_req.wdata[GFM_PINS-1:0];
            end else if (reg_req.addr == GFM_ADDR_OSEL2) begin
                osel2_d = reg_req.wdata[GFM_PINS-1:0];
            end else if (reg_req.addr == GFM_ADDR_OSEL1) begin
                osel1_d = reg_req.wdata[GFM_PINS-1:0];
            end else if (reg_req.addr == GFM_ADDR_OSEL0) begin
                osel0_d = reg_req.wdata[GFM_PINS-1:0];
            end else if (reg_req.addr == GFM_ADDR_OUTVAL) begin
                out_val_d = reg_req.wdata[GFM_PINS-1:0];
            end
        end
        if (reg_req.rd) begin
            if (reg_req.addr == GFM_ADDR_DIR) begin
                rdata_d = GFM_DW'(dir_q);
            end else if (reg_req.addr == GFM_ADDR_ISEL2) begin
                rdata_d = GFM_DW'(isel2_q);
            end else if (reg_req.addr == GFM_ADDR_ISEL1) begin
                rdata_d = GFM_DW'(isel1_q);
            end else if (reg_req.addr == GFM_ADDR_ISEL0) begin
                rdata_d = GFM_DW'(isel0_q);
            end else if (reg_req.addr == GFM_ADDR_OSEL2) begin
                rdata_d = GFM_DW'(osel2_q);
            end else if (reg_req.addr == GFM_ADDR_OSEL1) begin
                rdata_d = GFM_DW'(osel1_q);
            end else if (reg_req.addr == GFM_ADDR_OSEL0) begin
                rdata_d = GFM_DW'(osel0_q);
            end else if (reg_req.addr == GFM_ADDR_OUTVAL) begin
                rdata_d = GFM_DW'(out_val_q);
            end else if (reg_req.addr == GFM_ADDR_INVAL) begin
                rdata_d = GFM_DW'(in_val_q);
            end else begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dir_q <= GFM_DIR_RST;
            isel2_q <= GFM_ISEL2_RST;
            isel1_q <= GFM_ISEL1_RST;
            isel0_q <= GFM_ISEL0_RST;
            osel2_q <= GFM_OSEL2_RST;
            osel1_q <= GFM_OSEL1_RST;
            osel0_q <= GFM_OSEL0_RST;
            out_val_q <= GFM_OUTVAL_RST;
            in_val_q <= '0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            dir_q <= dir_d;
            isel2_q <= isel2_d;
            isel1_q <= isel1_d;
            isel0_q <= isel0_d;
            osel2_q <= osel2_d;
            osel1_q <= osel1_d;
            osel0_q <= osel0_d;
            out_val_q <= out_val_d;
            in_val_q <= in_val_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // -----------------------------------------------------------------
    // pin function mux
    // -----------------------------------------------------------------
    logic [GFM_PINS-1:0] gout_q, gout_d;
    logic [GFM_PINS-1:0] goe_q, goe_d;
    logic [GFM_CLKS-1:0] coe_q, coe_d;
    logic [GFM_CLKS-1:0] cact_q, cact_d;
    logic refsel_q, refsel_d;
    logic refsel_act_q, refsel_act_d;

    always_comb begin
        gout_d = '0;
        goe_d = '0;
        coe_d = '0;
        cact_d = '0;
        refsel_d = 1'b0;
        refsel_act_d = 1'b0;
        for (int i = 0; i < GFM_PINS; i++) begin
            if (dir_q[i]) begin
                goe_d[i] = 1'b1;
                case (osel[i])
                    GFM_FN_PLAIN: begin
                        gout_d[i] = out_val_q[i];
                    end
                    GFM_FN_ALT_A: begin
                        if (i == 0) begin
                            gout_d[i] = status.loss_of_lock;
                        end else if (i == 1) begin
                            gout_d[i] = status.holdover;
                        end else if (i == GFM_REFSEL_PIN) begin
                            gout_d[i] = status.ref_los[0];
                        end
                    end
                    GFM_FN_ALT_B: begin
                        if (i >= GFM_REFSEL_PIN) begin
                            gout_d[i] = status.ref_los[1];
                        end
                    end
                    GFM_FN_REFSEL: begin
                        // the select is a level from the board, so the
                        // driver is released even in output mode
                        if (i == GFM_REFSEL_PIN) begin
                            goe_d[i] = 1'b0;
                            refsel_d = pin_sync[i];
                            refsel_act_d = 1'b1;
                        end
                    end
                    default: begin
                        // reserved codes drive low
                    end
                endcase
            end else begin
                case (isel[i])
                    GFM_FN_ALT_A: begin
                        coe_d[i] = pin_sync[i];
                        cact_d[i] = 1'b1;
                    end
                    GFM_FN_ALT_B: begin
                        coe_d[i + GFM_ALT_B_OFS] = pin_sync[i];
                        cact_d[i + GFM_ALT_B_OFS] = 1'b1;
                    end
                    GFM_FN_REFSEL: begin
                        if (i == GFM_REFSEL_PIN) begin
                            refsel_d = pin_sync[i];
                            refsel_act_d = 1'b1;
                        end
                    end
                    default: begin
                        // plain input or reserved: no side function
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gout_q <= '0;
            goe_q <= GFM_DIR_RST;
            coe_q <= '0;
            cact_q <= '0;
            refsel_q <= 1'b0;
            refsel_act_q <= 1'b0;
        end else if (ce) begin
            gout_q <= gout_d;
            goe_q <= goe_d;
            coe_q <= coe_d;
            cact_q <= cact_d;
            refsel_q <= refsel_d;
            refsel_act_q <= refsel_act_d;
        end
    end

    assign gpio_out = gout_q;
    assign gpio_oe = goe_q;
    assign clk_oe_ctrl = coe_q;
    assign clk_oe_ctrl_active = cact_q;
    assign manual_reference_select = refsel_q;
    assign manual_reference_select_active = refsel_act_q;
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_reset_state: assert property (disable iff (1'b0)
        !rst_n |=> gpio_oe == GFM_DIR_RST && dir_q == GFM_DIR_RST
            && out_val_q == GFM_OUTVAL_RST && osel[0] == GFM_FN_ALT_A)
        else $error("reset state wrong");
    chk_plain_status: assert property (
        ce && !dir_q[3] && isel[3] == GFM_FN_PLAIN ##1 ce && reg_req.rd
            && reg_req.addr == GFM_ADDR_INVAL
        |=> reg_rvalid && reg_rdata[3] == $past(pin_sync[3], 2))
        else $error("input status not reflected");
    chk_input_gate: assert property (
        ce && dir_q[1] |=> !clk_oe_ctrl_active[1]
            && !clk_oe_ctrl_active[5])
        else $error("input function active in output mode");
    chk_pin0_clk4: assert property (
        ce && !dir_q[0] && isel[0] == GFM_FN_ALT_B
        |=> clk_oe_ctrl_active[4] && clk_oe_ctrl[4] == $past(pin_sync[0]))
        else $error("pin0 not steering clock 4");
    chk_pin3_clk3: assert property (
        ce && !dir_q[3] && isel[3] == GFM_FN_ALT_A
        |=> clk_oe_ctrl_active[3] && clk_oe_ctrl[3] == $past(pin_sync[3]))
        else $error("pin3 not steering clock 3");
    chk_pin2_refsel: assert property (
        ce && isel[2] == GFM_FN_REFSEL && !dir_q[2]
        |=> manual_reference_select_active && !gpio_oe[2]
            && manual_reference_select == $past(pin_sync[2]))
        else $error("pin2 reference select wrong");
    chk_output_gate: assert property (
        ce && !dir_q[2] |=> !gpio_oe[2] && !gpio_out[2])
        else $error("input pin driven");
    chk_sw_value: assert property (
        ce && dir_q[3] && osel[3] == GFM_FN_PLAIN
        |=> gpio_oe[3] && gpio_out[3] == $past(out_val_q[3]))
        else $error("software value not driven");
    chk_lol_drive: assert property (
        ce && dir_q[0] && osel[0] == GFM_FN_ALT_A
        |=> gpio_oe[0] && gpio_out[0] == $past(status.loss_of_lock))
        else $error("loss of lock not driven");
    chk_holdover: assert property (
        ce && dir_q[1] && osel[1] == GFM_FN_ALT_A
        |=> gpio_out[1] == $past(status.holdover))
        else $error("holdover not driven");
    chk_los_drive: assert property (
        ce && dir_q[3] && osel[3] == GFM_FN_ALT_B
        |=> gpio_out[3] == $past(status.ref_los[1]))
        else $error("ref1 los not driven on pin3");
    chk_sel_write: assert property (
        ce && reg_req.wr && reg_req.addr == GFM_ADDR_OSEL1
        |=> osel1_q == $past(reg_req.wdata[GFM_PINS-1:0]))
        else $error("selector write lost");

    cov_lol_pin: cover property (
        ce && dir_q[0] && osel[0] == GFM_FN_ALT_A ##1 gpio_out[0]);
    cov_refsel: cover property (
        ce && !dir_q[2] && isel[2] == GFM_FN_REFSEL ##1
            manual_reference_select);
    cov_clk_oe: cover property (ce ##1 clk_oe_ctrl_active[6]);
    cov_status_rd: cover property (
        ce && reg_req.rd && reg_req.addr == GFM_ADDR_INVAL ##1 reg_rvalid);

endmodule

`default_nettype wire

/* gfm_gpio_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module gfm_gpio_mux_tb_top;
    import gfm_pkg::*;

    // -------------------------------------------------------------------
    // stimulus and observed signals
    // -------------------------------------------------------------------
    localparam int LIMIT = 4000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    gfm_reg_req_t reg_req = '0;
    gfm_status_t status = '0;
    logic [GFM_PINS-1:0] board_val = 4'h0;
    logic [GFM_PINS-1:0] board_en = 4'h0;
    logic [GFM_PINS-1:0] pin_level;
    logic [GFM_PINS-1:0] gpio_out;
    logic [GFM_PINS-1:0] gpio_oe;
    logic [GFM_DW-1:0] reg_rdata;
    logic reg_rvalid;
    logic mrs;
    logic mrs_act;
    logic [GFM_CLKS-1:0] clk_oe;
    logic [GFM_CLKS-1:0] clk_act;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] rst_exp [9] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h01, 8'h00, 8'h00};

    always #2.5 clock = ~clock;

    gfm_gpio_mux uut (
        .clock(clock), .rst_n(rst_n), .ce(1'b1), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .status(status),
        .gpio_in(pin_level), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .clk_oe_ctrl(clk_oe), .clk_oe_ctrl_active(clk_act),
        .manual_reference_select(mrs),
        .manual_reference_select_active(mrs_act)
    );

    gfm_board_model board (
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .board_val(board_val),
        .board_en(board_en), .pin_level(pin_level)
    );

    // -------------------------------------------------------------------
    // access and compare tasks
    // -------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk_port(input string nm, input logic [7:0] exp,
                            input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one-cycle strobe; the pins follow one edge after the register
    task automatic reg_wr(input logic [GFM_AW-1:0] a,
                          input logic [GFM_DW-1:0] d);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        reg_req = '0;
        tick(2);
    endtask

    task automatic chk_reg(input logic [GFM_AW-1:0] a,
                           input logic [7:0] exp);
        int n;
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick(1);
        reg_req = '0;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) tick(1);
        chk_port("read_valid", 8'h01, {7'h00, reg_rvalid});
        chk_port($sformatf("reg_%h", a), exp, reg_rdata);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            $display("mismatch timeout expected done seen running");
            test_done();
        end
    end

    // -------------------------------------------------------------------
    // tests
    // -------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk_port("pin_oe", 8'h01, {4'h0, gpio_oe});
        for (int i = 0; i < 9; i++) chk_reg(16'(GFM_ADDR_DIR + i), rst_exp[i]);
        status.loss_of_lock = 1'b1;
        tick(2);
        chk_port("pin_drive", 8'h01, {4'h0, gpio_out});
        status = '0;
        tick(2);
        chk_port("pin_drive", 8'h00, {4'h0, gpio_out});
        $display("test reset_values done");

        // refused writes; software keeps reserved bits at zero
        reg_wr(GFM_ADDR_INVAL, 8'h0F);
        chk_reg(GFM_ADDR_INVAL, 8'h00);
        chk_reg(16'h0080, 8'h00);
        $display("test refused_access done");

        reg_wr(GFM_ADDR_DIR, 8'h0F);
        reg_wr(GFM_ADDR_OSEL0, 8'h00);
        reg_wr(GFM_ADDR_OUTVAL, 8'h0A);
        chk_port("pin_oe", 8'h0F, {4'h0, gpio_oe});
        chk_port("pin_drive", 8'h0A, {4'h0, gpio_out});
        reg_wr(GFM_ADDR_OSEL1, 8'h0C);
        reg_wr(GFM_ADDR_OSEL0, 8'h03);
        status = gfm_status_t'(4'hA);
        tick(2);
        chk_port("pin_drive", 8'h0D, {4'h0, gpio_out});
        status = gfm_status_t'(4'h5);
        tick(2);
        chk_port("pin_drive", 8'h02, {4'h0, gpio_out});
        reg_wr(GFM_ADDR_OSEL1, 8'h08);
        reg_wr(GFM_ADDR_OSEL0, 8'h07);
        chk_port("pin_drive", 8'h06, {4'h0, gpio_out});
        reg_wr(GFM_ADDR_OSEL1, 8'h00);
        reg_wr(GFM_ADDR_OSEL0, 8'h0F);
        status = gfm_status_t'(4'hF);
        tick(2);
        chk_port("pin_drive", 8'h07, {4'h0, gpio_out});
        chk_port("pin_oe", 8'h0F, {4'h0, gpio_oe});
        board_en = 4'h4;
        board_val = 4'h4;
        reg_wr(GFM_ADDR_OSEL2, 8'h04);
        tick(4);
        chk_port("pin_oe", 8'h0B, {4'h0, gpio_oe});
        chk_port("refsel", 8'h03, {6'h00, mrs_act, mrs});
        board_val = 4'h0;
        tick(4);
        chk_port("refsel", 8'h02, {6'h00, mrs_act, mrs});
        $display("test output_modes done");

        reg_wr(GFM_ADDR_OSEL2, 8'h00);
        board_en = 4'hF;
        board_val = 4'hA;
        reg_wr(GFM_ADDR_DIR, 8'h00);
        tick(4);
        chk_port("pin_oe", 8'h00, {4'h0, gpio_oe});
        chk_reg(GFM_ADDR_INVAL, 8'h0A);
        reg_wr(GFM_ADDR_ISEL2, 8'h04);
        reg_wr(GFM_ADDR_ISEL1, 8'h02);
        reg_wr(GFM_ADDR_ISEL0, 8'h0D);
        board_val = 4'hF;
        tick(4);
        chk_port("clk_owner", 8'h29, clk_act);
        chk_port("clk_level", 8'h29, clk_oe);
        chk_port("refsel", 8'h03, {6'h00, mrs_act, mrs});
        chk_reg(GFM_ADDR_INVAL, 8'h00);
        reg_wr(GFM_ADDR_ISEL2, 8'h00);
        reg_wr(GFM_ADDR_ISEL1, 8'h0D);
        reg_wr(GFM_ADDR_ISEL0, 8'h02);
        board_val = 4'h5;
        tick(4);
        chk_port("clk_owner", 8'hD2, clk_act);
        chk_port("clk_level", 8'h50, clk_oe);
        chk_port("refsel_owner", 8'h00, {7'h00, mrs_act});
        board_en = 4'hE;
        reg_wr(GFM_ADDR_DIR, 8'h01);
        tick(4);
        chk_port("clk_owner", 8'hC2, clk_act);
        $display("test input_modes done");
        test_done();
    end
endmodule

`default_nettype wire

/* gfm_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module gfm_pin_sync #(
    parameter int W = 4
) (
    input wire logic clock,         // system clock
    input wire logic rst_n,         // synchronous reset, active low
    input wire logic ce,            // clock enable
    input wire logic [W-1:0] d_in,  // asynchronous pin levels
    output logic [W-1:0] q_out      // synchronised levels
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    initial begin
        if (W < 1) $error("gfm_pin_sync: W must be at least 1");
    end

    // first stage is read only by the second stage
    always_comb begin
        meta_d = d_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_out = sync_q;

endmodule

`default_nettype wire

/* gfm_pkg.sv */
package gfm_pkg;

    // -----------------------------------------------------------------
    // widths
    // -----------------------------------------------------------------
    localparam int GFM_PINS = 4;
    localparam int GFM_CLKS = 8;
    localparam int GFM_AW = 16;
    localparam int GFM_DW = 8;
    localparam int GFM_SELW = 3;
    // clock output steered by code "alt b" sits this far above the pin
    localparam int GFM_ALT_B_OFS = 4;
    localparam int GFM_REFSEL_PIN = 2;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [GFM_AW-1:0] GFM_ADDR_DIR = 16'h006E;
    localparam logic [GFM_AW-1:0] GFM_ADDR_ISEL2 = 16'h006F;
    localparam logic [GFM_AW-1:0] GFM_ADDR_ISEL1 = 16'h0070;
    localparam logic [GFM_AW-1:0] GFM_ADDR_ISEL0 = 16'h0071;
    localparam logic [GFM_AW-1:0] GFM_ADDR_OSEL2 = 16'h0072;
    localparam logic [GFM_AW-1:0] GFM_ADDR_OSEL1 = 16'h0073;
    localparam logic [GFM_AW-1:0] GFM_ADDR_OSEL0 = 16'h0074;
    localparam logic [GFM_AW-1:0] GFM_ADDR_RSVD = 16'h0075;
    localparam logic [GFM_AW-1:0] GFM_ADDR_OUTVAL = 16'h0076;
    localparam logic [GFM_AW-1:0] GFM_ADDR_INVAL = 16'h0219;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [GFM_PINS-1:0] GFM_DIR_RST = 4'h1;
    localparam logic [GFM_PINS-1:0] GFM_ISEL2_RST = 4'h0;
    localparam logic [GFM_PINS-1:0] GFM_ISEL1_RST = 4'h0;
    localparam logic [GFM_PINS-1:0] GFM_ISEL0_RST = 4'h0;
    localparam logic [GFM_PINS-1:0] GFM_OSEL2_RST = 4'h0;
    localparam logic [GFM_PINS-1:0] GFM_OSEL1_RST = 4'h0;
    localparam logic [GFM_PINS-1:0] GFM_OSEL0_RST = 4'h1;
    localparam logic [GFM_PINS-1:0] GFM_OUTVAL_RST = 4'h0;

    // -----------------------------------------------------------------
    // selector codes
    // -----------------------------------------------------------------
    localparam logic [GFM_SELW-1:0] GFM_FN_PLAIN = 3'h0;
    localparam logic [GFM_SELW-1:0] GFM_FN_ALT_A = 3'h1;
    localparam logic [GFM_SELW-1:0] GFM_FN_ALT_B = 3'h2;
    localparam logic [GFM_SELW-1:0] GFM_FN_REFSEL = 3'h5;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [GFM_AW-1:0] addr;
        logic [GFM_DW-1:0] wdata;
    } gfm_reg_req_t;

    typedef struct packed {
        logic loss_of_lock;
        logic holdover;
        logic [1:0] ref_los;
    } gfm_status_t;

endpackage
